/* File: fcr_pkg.sv */
/*
  Constants for the framer command register block: register byte offsets,
  bit positions, reset values and bus response codes.
  Assumes a 32-bit AXI4-Lite register bus with byte addressing.
*/
package fcr_pkg;

  // Bus widths and responses.
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register byte offsets.
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_FLAGS = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFF_CONDITION_REGISTER = 8'h10;

  // Command register bit positions.
  localparam int CMD_ADDR0 = 0;
  localparam int CMD_ADDR1 = 1;
  localparam int CMD_ADDR2 = 2;
  localparam int CMD_ADDR3_TEST = 3;
  localparam int CMD_START = 4;
  localparam int CMD_ERR_ACK = 5;
  localparam int CMD_TX_ACK = 6;
  localparam int CMD_RX_ACK = 7;

  // Condition register bit positions.
  localparam int CONDITION_REGISTER_SOFT_RESET = 0;
  localparam int CONDITION_REGISTER_CONFIG = 1;

  // Interrupt status and mask bit positions.
  localparam int IRQ_ERR = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_RX = 2;
  localparam int IRQ_LAUNCH = 3;
  localparam int IRQ_W = 4;

  // Reset values.
  localparam logic [4:0] CMD_RESET = 5'h00;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;
  localparam logic CONFIG_RESET = 1'b0;

  // Falling edges of octet sync after a start request before launch.
  localparam logic [1:0] SYNC_EDGES_TO_LAUNCH = 2'h2;

endpackage

/* File: fcr_top.sv */
/*
  Command register of a multiframe framer behind an AXI4-Lite slave, with
  transmitter start alignment to octet sync and interrupt flag handling.
  Assumes one 40 MHz clock, asynchronous active-high reset, event inputs
  from logic on the same clock, and the mode and sync pins asynchronous.
*/
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module fcr_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [fcr_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [fcr_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [fcr_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [fcr_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mode_test_pin,
  input wire logic octet_sync_input,
  input wire logic err_event,
  input wire logic tx_event,
  input wire logic rx_event,
  output logic [3:0] data_reg_addr,
  output logic test_mode,
  output logic tx_launch,
  output logic tx_armed,
  output logic error_irq,
  output logic tx_irq,
  output logic rx_irq,
  output logic irq
);
  import fcr_pkg::*;

  // Decodes a register offset from the word-aligned part of an address.
  function automatic logic addr_is(input logic [AXI_ADDR_W-1:0] a,
                                   input logic [7:0] off);
    addr_is = (a[AXI_ADDR_W-1:2] == off[AXI_ADDR_W-1:2]);
  endfunction

  // Tells whether an address hits any mapped register.
  function automatic logic addr_mapped(input logic [AXI_ADDR_W-1:0] a);
    addr_mapped = addr_is(a, OFF_CMD) || addr_is(a, OFF_FLAGS) ||
                  addr_is(a, OFF_IRQ_STAT) || addr_is(a, OFF_IRQ_MASK) ||
                  addr_is(a, OFF_CONDITION_REGISTER);
  endfunction

  logic aw_have_r;
  logic w_have_r;
  logic [AXI_ADDR_W-1:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic w_lane0_r;
  logic wr_fire;
  logic wr_lane;
  logic rd_fire;
  logic [4:0] cmd_r;
  logic start_d_r;
  logic start_rise;
  logic config_r;
  logic soft_reset;
  logic ack_err;
  logic ack_tx;
  logic ack_rx;
  logic err_flag_r;
  logic tx_flag_r;
  logic rx_flag_r;
  logic err_set;
  logic tx_set;
  logic rx_set;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_events;
  logic mode_s1_r;
  logic mode_s2_r;
  logic sync_s1_r;
  logic sync_s2_r;
  logic sync_s3_r;
  logic sync_fall;
  logic [1:0] sync_edges_r;
  logic launch_now;
  logic [7:0] rd_byte;

  // A write is carried out once both address and data are held.
  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_lane = wr_fire && w_lane0_r;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // Write address channel: take the address, then wait for the response.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_have_r <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel: only the low byte lane carries register bits.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_have_r <= 1'b0;
      w_data_r <= 8'h00;
      w_lane0_r <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r <= 1'b1;
      w_data_r <= s_axi_wdata[7:0];
      w_lane0_r <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_have_r <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response: unmapped addresses answer with a slave error.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Write strobes of the single-cycle command and condition bits.
  assign soft_reset = wr_lane && addr_is(aw_addr_r, OFF_CONDITION_REGISTER) &&
                      w_data_r[CONDITION_REGISTER_SOFT_RESET];
  assign ack_err = wr_lane && addr_is(aw_addr_r, OFF_CMD) &&
                   w_data_r[CMD_ERR_ACK];
  assign ack_tx = wr_lane && addr_is(aw_addr_r, OFF_CMD) &&
                  w_data_r[CMD_TX_ACK];
  assign ack_rx = wr_lane && addr_is(aw_addr_r, OFF_CMD) &&
                  w_data_r[CMD_RX_ACK];

  // Stored command bits; soft reset clears test select and start.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_r <= CMD_RESET;
    end else if (soft_reset) begin
      cmd_r[CMD_ADDR3_TEST] <= 1'b0;
      cmd_r[CMD_START] <= 1'b0;
    end else if (wr_lane && addr_is(aw_addr_r, OFF_CMD)) begin
      cmd_r <= w_data_r[4:0];
    end
  end

  // Configuration option lives beside the soft reset in the condition reg.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      config_r <= CONFIG_RESET;
    end else if (wr_lane && addr_is(aw_addr_r, OFF_CONDITION_REGISTER)) begin
      config_r <= w_data_r[CONDITION_REGISTER_CONFIG];
    end
  end

  // Rising edge of the start bit, however briefly it was set.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_d_r <= 1'b0;
    end else begin
      start_d_r <= cmd_r[CMD_START];
    end
  end
  assign start_rise = cmd_r[CMD_START] && !start_d_r;

  // Two-flop synchronisers for the asynchronous pins.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_s1_r <= 1'b0;
      mode_s2_r <= 1'b0;
      sync_s1_r <= 1'b0;
      sync_s2_r <= 1'b0;
      sync_s3_r <= 1'b0;
    end else begin
      mode_s1_r <= mode_test_pin;
      mode_s2_r <= mode_s1_r;
      sync_s1_r <= octet_sync_input;
      sync_s2_r <= sync_s1_r;
      sync_s3_r <= sync_s2_r;
    end
  end
  assign sync_fall = sync_s3_r && !sync_s2_r;

  // Launch waits for the second falling sync edge after the start request.
  // A fresh start in the same cycle restarts the wait; a soft reset in that cycle cancels the request.
  assign launch_now = tx_armed && sync_fall && !start_rise && !soft_reset &&
                      (sync_edges_r == SYNC_EDGES_TO_LAUNCH - 2'h1);

  // Arming and edge counting of the transmitter start.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_armed <= 1'b0;
      sync_edges_r <= 2'h0;
    end else if (soft_reset) begin
      tx_armed <= 1'b0;
      sync_edges_r <= 2'h0;
    end else if (start_rise) begin
      tx_armed <= 1'b1;
      sync_edges_r <= 2'h0;
    end else if (launch_now) begin
      tx_armed <= 1'b0;
      sync_edges_r <= 2'h0;
    end else if (tx_armed && sync_fall) begin
      sync_edges_r <= sync_edges_r + 2'h1;
    end
  end

  // One-cycle pulse telling the framer to send frame one, bit one.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_launch <= 1'b0;
    end else begin
      tx_launch <= launch_now;
    end
  end

  // Data register address and test mode, with the pin-driven overrides.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_reg_addr <= 4'h0;
      test_mode <= 1'b0;
    end else if (config_r) begin
      data_reg_addr <= cmd_r[3:0];
      test_mode <= mode_s2_r;
    end else begin
      data_reg_addr[CMD_ADDR0] <= mode_s2_r | cmd_r[CMD_ADDR0];
      data_reg_addr[CMD_ADDR1] <= mode_s2_r ? 1'b0 : cmd_r[CMD_ADDR1];
      data_reg_addr[CMD_ADDR2] <= mode_s2_r ? 1'b0 : cmd_r[CMD_ADDR2];
      data_reg_addr[CMD_ADDR3_TEST] <= 1'b0;
      test_mode <= cmd_r[CMD_ADDR3_TEST];
    end
  end

  // Flags are raised only while interrupts are enabled by the start bit.
  assign err_set = err_event && cmd_r[CMD_START];
  assign tx_set = tx_event && cmd_r[CMD_START];
  assign rx_set = rx_event && cmd_r[CMD_START];

  // Interrupt flags: an event in the acknowledge cycle wins over the clear.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_flag_r <= 1'b0;
      tx_flag_r <= 1'b0;
      rx_flag_r <= 1'b0;
    end else begin
      err_flag_r <= err_set | (err_flag_r & !ack_err);
      tx_flag_r <= tx_set | (tx_flag_r & !ack_tx);
      rx_flag_r <= rx_set | (rx_flag_r & !ack_rx);
    end
  end

  // Events that latch into the sticky interrupt status.
  assign irq_events[IRQ_ERR] = err_set;
  assign irq_events[IRQ_TX] = tx_set;
  assign irq_events[IRQ_RX] = rx_set;
  assign irq_events[IRQ_LAUNCH] = launch_now;

  // Sticky status, cleared by a read; a new event in that cycle survives.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_r <= '0;
    end else if (rd_fire && addr_is(s_axi_araddr, OFF_IRQ_STAT)) begin
      irq_stat_r <= irq_events;
    end else begin
      irq_stat_r <= irq_stat_r | irq_events;
    end
  end

  // Interrupt mask, same layout as the status.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_mask_r <= IRQ_MASK_RESET;
    end else if (wr_lane && addr_is(aw_addr_r, OFF_IRQ_MASK)) begin
      irq_mask_r <= w_data_r[IRQ_W-1:0];
    end
  end

  // Interrupt outputs, all silenced while the start bit is low.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      error_irq <= 1'b0;
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
      irq <= 1'b0;
    end else begin
      error_irq <= err_flag_r && cmd_r[CMD_START];
      tx_irq <= tx_flag_r && cmd_r[CMD_START];
      rx_irq <= rx_flag_r && cmd_r[CMD_START];
      irq <= (|(irq_stat_r & irq_mask_r)) && cmd_r[CMD_START];
    end
  end

  // Read multiplexer; acknowledge and soft reset bits read as zero.
  always_comb begin
    rd_byte = 8'h00;
    if (addr_is(s_axi_araddr, OFF_CMD)) begin
      rd_byte = {3'h0, cmd_r};
    end else if (addr_is(s_axi_araddr, OFF_FLAGS)) begin
      rd_byte = {rx_flag_r, tx_flag_r, err_flag_r, 5'h00};
    end else if (addr_is(s_axi_araddr, OFF_IRQ_STAT)) begin
      rd_byte = {4'h0, irq_stat_r};
    end else if (addr_is(s_axi_araddr, OFF_IRQ_MASK)) begin
      rd_byte = {4'h0, irq_mask_r};
    end else if (addr_is(s_axi_araddr, OFF_CONDITION_REGISTER)) begin
      rd_byte = {6'h00, config_r, 1'b0};
    end
  end

  // Read channel: one read at a time, answered the cycle after the address.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* File: fcr_sync_src.sv */
/*
  Octet sync source standing in for the framing logic.
  Assumes the bench clock; the line idles high while not running.
*/
`timescale 1ns/1ps
module fcr_sync_src (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  output logic sync
);
  logic [2:0] cnt_r;

  // Toggles the line every eight clocks while running, else holds it high.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 3'h0;
      sync <= 1'b1;
    end else if (!run) begin
      cnt_r <= 3'h0;
      sync <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 3'h1;
      if (cnt_r == 3'h7) begin
        sync <= ~sync;
      end
    end
  end
endmodule

/* File: fcr_top_chk.sv */
/*
  Bus handshake and launch checks for the command register.
  Bound to fcr_top and sees only its ports.
*/
`timescale 1ns/1ps
module fcr_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [fcr_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_launch,
  input wire logic tx_armed
);
  // All checks share one clock and pause in reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // A write answer held back by the host.
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence

  // A start request that has just been armed.
  sequence s_arm;
    $rose(tx_armed);
  endsequence

  chk_bresp_hold:
    assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  chk_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  chk_write_busy:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  chk_read_busy:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  chk_launch_pulse:
    assert property (tx_launch |=> !tx_launch)
    else $error("launch pulse too long");
  chk_launch_armed:
    assert property (tx_launch |-> $past(tx_armed))
    else $error("launch without request");
  chk_armed_drop:
    assert property (tx_launch |-> !tx_armed)
    else $error("request kept after launch");
  chk_launch_wait:
    assert property (s_arm |-> !tx_launch [*3])
    else $error("launch before two sync edges");
endmodule

bind fcr_top fcr_chk u_chk (.clk(clk), .rst(rst),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .tx_launch(tx_launch),
  .tx_armed(tx_armed));

/* File: tb.sv */
/*
  Self-checking bench for the framer command register.
  Drives the bus, pins and events; octet sync comes from the model.
*/
`timescale 1ns/1ps
module tb;
  import fcr_pkg::*;
  logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, pin = 0, run = 0;
  logic [2:0] ev = 3'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rnd = 32'h38763135, rdata;
  logic [1:0] bresp, rresp, br;
  logic awready, wready, bvalid, arready, rvalid, sync, test, launch;
  logic armed, eirq, tirq, rirq, irq;
  logic [3:0] addr;
  logic [33:0] exp_q[$], msk_q[$];
  int mismatches = 0, num_checks = 0, cyc = 0, falls = 0;

  fcr_top u_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .mode_test_pin(pin),
    .octet_sync_input(sync), .err_event(ev[0]), .tx_event(ev[1]),
    .rx_event(ev[2]), .data_reg_addr(addr), .test_mode(test),
    .tx_launch(launch), .tx_armed(armed), .error_irq(eirq),
    .tx_irq(tirq), .rx_irq(rirq), .irq(irq));
  fcr_sync_src u_sync (.clk(clk), .rst(rst), .run(run), .sync(sync));

  // Clock, sync edge counter and hang guard.
  always #12.5 clk = ~clk;
  always @(negedge sync) falls++;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      conclude();
    end
  end

  // Compares each read answer with the oldest note.
  always @(posedge clk) begin
    if (rvalid && rready) begin
      cmp_rd({rresp, rdata}, exp_q.pop_front(), msk_q.pop_front());
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cmp_rd(input logic [33:0] g, e, m);
    num_checks++;
    if (((g ^ e) & m) !== 34'h0) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g & m, e);
    end
  endtask

  task automatic cmp_pin(input logic [3:0] g, e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Bus write; bready stands with the request until the answer is seen.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    br = bresp;
    bready <= 1'b0;
  endtask

  // Bus read; the expected answer is noted before the request.
  task automatic rd(input logic [7:0] a, input logic [33:0] e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask

  task automatic settle();
    repeat (6) @(posedge clk);
  endtask

  task automatic pulse();
    ev <= 3'h7;
    @(posedge clk);
    ev <= 3'h0;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence: reset, addressing, test mode, launch, interrupts.
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_CMD, 34'h0, '1);
    rd(OFF_IRQ_MASK, 34'h0, '1);
    wr(OFF_CONDITION_REGISTER, 32'h2);
    rnd = lfsr(rnd);
    wr(OFF_CMD, {28'h0, rnd[3:0]});
    pin <= 1'b1;
    settle();
    cmp_pin(addr, rnd[3:0]);
    cmp_pin({3'h0, test}, 4'h1);
    wr(OFF_CONDITION_REGISTER, 32'h0);
    wr(OFF_CMD, 32'h0E);
    settle();
    cmp_pin(addr, 4'h1);
    cmp_pin({3'h0, test}, 4'h1);
    wr(OFF_CONDITION_REGISTER, 32'h1);
    pin <= 1'b0;
    settle();
    cmp_pin({3'h0, test}, 4'h0);
    cmp_pin(addr, 4'h6);
    rd(OFF_CMD, 34'h06, '1);
    wr(OFF_CMD, 32'h10);
    wr(OFF_CMD, 32'h00);
    cmp_pin({3'h0, armed}, 4'h1);
    falls = 0;
    run <= 1'b1;
    while (launch !== 1'b1) @(posedge clk);
    cmp_pin(falls[3:0], 4'h2);
    run <= 1'b0;
    rd(OFF_IRQ_STAT, 34'h8, '1);
    pulse();
    rd(OFF_FLAGS, 34'h0, '1);
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_CMD, 32'h10);
    pulse();
    settle();
    cmp_pin({eirq, tirq, rirq, irq}, 4'hF);
    rd(OFF_IRQ_STAT, 34'h7, 34'h7);
    rd(OFF_IRQ_STAT, 34'h0, 34'h7);
    settle();
    cmp_pin({eirq, tirq, rirq, irq}, 4'hE);
    wr(OFF_CMD, 32'h00);
    settle();
    cmp_pin({eirq, tirq, rirq, irq}, 4'h0);
    wr(OFF_CMD, 32'h30);
    settle();
    cmp_pin({eirq, tirq, rirq, irq}, 4'h6);
    rd(OFF_FLAGS, 34'hC0, '1);
    wr(OFF_CMD, 32'hD0);
    rd(OFF_FLAGS, 34'h0, '1);
    wr(8'h14, 32'h0);
    cmp_pin({2'h0, br}, {2'h0, RESP_SLVERR});
    rd(8'h14, {RESP_SLVERR, 32'h0}, '1);
    settle();
    conclude();
  end
endmodule
